// *** rtl/svd_top.sv ***
// Control, flag and interrupt logic of the supply threshold detector.
// Assumes the comparator outputs and the settle tick arrive asynchronously.
//
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ns
module svd_top #(
	parameter int SETTLE_TICKS = svd_pkg::SETTLE_TICKS
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        settle_tick,
	input  wire logic        ref_user_enable,
	input  wire logic        divider_above,
	input  wire logic        external_trip_input,
	input  wire logic        sleep_mode,
	output logic      [3:0]  trip_level_select,
	output logic             detector_power,
	output logic             irq,
	output logic             wake_request,
	output logic             vector_request
);
	// Indices of the asynchronous inputs inside the synchroniser bank.
	localparam int SYNC_WIDTH = 4;
	localparam int IDX_TICK   = 0;
	localparam int IDX_DIV    = 1;
	localparam int IDX_EXT    = 2;
	localparam int IDX_REF    = 3;

	// Software-visible registers.
	logic [7:0]            ctrl_reg;
	logic [7:0]            core_reg;
	logic [7:0]            flags_reg;
	logic [7:0]            enables_reg;
	logic [7:0]            prio_reg;

	// Settling state of the shared reference.
	logic                  stable_reg;
	logic [15:0]           settle_cnt_reg;

	// Two-stage synchronisers and edge history.
	logic [SYNC_WIDTH-1:0] async_in;
	logic [SYNC_WIDTH-1:0] meta_reg;
	logic [SYNC_WIDTH-1:0] sync_reg;
	logic                  tick_prev_reg;
	logic                  above_prev_reg;
	logic                  ref_prev_reg;

	// Bus handshake and write decode.
	logic                  wait_reg;
	logic                  request;
	logic                  wr;
	logic                  wr_control;
	logic                  wr_core;
	logic                  wr_flags;
	logic                  wr_enables;
	logic                  wr_prio;

	// Event path.
	logic                  above;
	logic                  rising;
	logic                  falling;
	logic                  crossing;
	logic                  restart;
	logic                  tick_edge;
	logic                  event_set;
	logic                  event_unmasked;

	// True when the bus address selects the given register.
	function automatic logic addr_hit(
		input logic [3:0] addr,
		input logic [3:0] target
	);
		return addr == target;
	endfunction : addr_hit

	function automatic logic [7:0] control_view(
		input logic [7:0] ctrl,
		input logic       stable
	);
		return {ctrl[svd_pkg::BIT_DIR], 1'b0, stable, ctrl[svd_pkg::BIT_EN], ctrl[3:0]};
	endfunction : control_view

	// Readback of the selected register; unmapped addresses read as zero.
	function automatic logic [7:0] read_view(
		input logic [3:0] addr,
		input logic [7:0] ctrl,
		input logic       stable,
		input logic [7:0] core,
		input logic [7:0] flags,
		input logic [7:0] enables,
		input logic [7:0] prio
	);
		logic [7:0] value;
		value = 8'h00;
		if (addr_hit(addr, svd_pkg::ADDR_CONTROL)) begin
			value = control_view(ctrl, stable);
		end else if (addr_hit(addr, svd_pkg::ADDR_CORE_INT)) begin
			value = core;
		end else if (addr_hit(addr, svd_pkg::ADDR_FLAGS2)) begin
			value = flags;
		end else if (addr_hit(addr, svd_pkg::ADDR_ENABLES2)) begin
			value = enables;
		end else if (addr_hit(addr, svd_pkg::ADDR_PRIO2)) begin
			value = prio;
		end
		return value;
	endfunction : read_view

	// All four inputs arrive from outside the clock domain.
	assign async_in[IDX_TICK] = settle_tick;
	assign async_in[IDX_DIV]  = divider_above;
	assign async_in[IDX_EXT]  = external_trip_input;
	assign async_in[IDX_REF]  = ref_user_enable;

	assign request    = avs_read || avs_write;
	// A write lands only at the edge at which waitrequest is seen low.
	assign wr         = avs_write && !wait_reg;
	assign wr_control = wr && addr_hit(avs_address, svd_pkg::ADDR_CONTROL);
	assign wr_core    = wr && addr_hit(avs_address, svd_pkg::ADDR_CORE_INT);
	assign wr_flags   = wr && addr_hit(avs_address, svd_pkg::ADDR_FLAGS2);
	assign wr_enables = wr && addr_hit(avs_address, svd_pkg::ADDR_ENABLES2);
	assign wr_prio    = wr && addr_hit(avs_address, svd_pkg::ADDR_PRIO2);

	assign above = (ctrl_reg[3:0] == svd_pkg::LEVEL_EXTERNAL) ?
		sync_reg[IDX_EXT] : sync_reg[IDX_DIV];
	assign rising  = above && !above_prev_reg;
	assign falling = !above && above_prev_reg;
	assign crossing = ctrl_reg[svd_pkg::BIT_DIR] ? rising : falling;
	assign restart = !ctrl_reg[svd_pkg::BIT_EN] ||
		(sync_reg[IDX_REF] && !ref_prev_reg);
	assign tick_edge = sync_reg[IDX_TICK] && !tick_prev_reg;
	assign event_set = crossing && stable_reg && ctrl_reg[svd_pkg::BIT_EN];
	// Flag and its enable, shared by the interrupt and wake paths.
	assign event_unmasked = flags_reg[svd_pkg::BIT_EVENT] &&
		enables_reg[svd_pkg::BIT_EVENT];

	// Two flip-flops per input; nothing but the second stage reads the first.
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_WIDTH; gi++) begin : g_sync
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					meta_reg[gi] <= 1'b0;
					sync_reg[gi] <= 1'b0;
				end else begin
					meta_reg[gi] <= async_in[gi];
					sync_reg[gi] <= meta_reg[gi];
				end
			end
		end
	endgenerate

	// Edge history resets to the idle level of every input, so no false edge follows reset.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tick_prev_reg <= 1'b0;
			above_prev_reg <= 1'b0;
			ref_prev_reg <= 1'b0;
		end else begin
			tick_prev_reg <= sync_reg[IDX_TICK];
			above_prev_reg <= above;
			ref_prev_reg <= sync_reg[IDX_REF];
		end
	end

	// Timed by settle tick.
	// The tick runs free of the system clock, so a clock change does not stretch settling.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			settle_cnt_reg <= 16'h0000;
			stable_reg <= 1'b0;
		end else if (restart) begin
			settle_cnt_reg <= 16'h0000;
			stable_reg <= 1'b0;
		end else if (tick_edge && !stable_reg) begin
			if (settle_cnt_reg == 16'(SETTLE_TICKS - 1)) begin
				stable_reg <= 1'b1;
			end
			settle_cnt_reg <= settle_cnt_reg + 16'h0001;
		end
	end

	// Reset to defaults.
	// Bits 6 and 5 are not stored: one reads zero, the other comes from the settle logic.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_reg <= {4'h0, svd_pkg::LEVEL_RESET};
		end else if (wr_control) begin
			ctrl_reg <= {avs_writedata[7], 2'b00, avs_writedata[4:0]};
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			core_reg <= 8'h00;
			enables_reg <= 8'h00;
			prio_reg <= svd_pkg::PRIO_RESET;
		end else begin
			if (wr_core) begin
				core_reg <= avs_writedata[7:0];
			end
			if (wr_enables) begin
				enables_reg <= avs_writedata[7:0];
			end
			if (wr_prio) begin
				prio_reg <= avs_writedata[7:0];
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			flags_reg <= 8'h00;
		end else begin
			if (wr_flags) begin
				flags_reg <= avs_writedata[7:0];
			end
			// The hardware set comes last so that it wins over a clear in the same cycle.
			if (event_set) begin
				flags_reg[svd_pkg::BIT_EVENT] <= 1'b1;
			end
		end
	end

	// One wait state keeps read data registered and the request edge unambiguous.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wait_reg <= 1'b1;
		end else begin
			wait_reg <= !(request && wait_reg);
		end
	end

	assign avs_waitrequest = wait_reg;

	// Read data is loaded every cycle, so it stands at the edge that ends the wait.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			avs_readdata <= 32'h0000_0000;
		end else begin
			avs_readdata <= {24'h00_0000, read_view(
				avs_address,
				ctrl_reg,
				stable_reg,
				core_reg,
				flags_reg,
				enables_reg,
				prio_reg
			)};
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq <= 1'b0;
		end else begin
			irq <= event_unmasked && core_reg[svd_pkg::BIT_GIE] && stable_reg;
		end
	end

	// Wake needs only sleep mode and the enabled event flag; the global enable decides the vector.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wake_request <= 1'b0;
			vector_request <= 1'b0;
		end else begin
			wake_request <= sleep_mode && event_unmasked;
			vector_request <= sleep_mode && event_unmasked &&
				core_reg[svd_pkg::BIT_GIE];
		end
	end

	// Registered copies steer the analog part without glitches from the bus decode.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			trip_level_select <= svd_pkg::LEVEL_RESET;
			detector_power <= 1'b0;
		end else begin
			trip_level_select <= ctrl_reg[3:0];
			detector_power <= ctrl_reg[svd_pkg::BIT_EN];
		end
	end
endmodule : svd_top

// *** rtl/svd_pkg.sv ***
// Constants for the supply threshold detector control block.
// Assumes a 20 MHz system clock and a separate free-running settle tick source.
package svd_pkg;
	localparam logic [3:0] ADDR_CONTROL  = 4'h0;
	localparam logic [3:0] ADDR_CORE_INT = 4'h1;
	localparam logic [3:0] ADDR_FLAGS2   = 4'h2;
	localparam logic [3:0] ADDR_ENABLES2 = 4'h3;
	localparam logic [3:0] ADDR_PRIO2    = 4'h4;
	localparam int BIT_DIR    = 7;
	localparam int BIT_STABLE = 5;
	localparam int BIT_EN     = 4;
	localparam int BIT_GIE    = 7;
	localparam int BIT_EVENT  = 2;
	localparam logic [3:0] LEVEL_EXTERNAL = 4'hf;
	localparam logic [3:0] LEVEL_RESET    = 4'h5;
	localparam logic [7:0] PRIO_RESET     = 8'h04;
	localparam int SETTLE_TICKS = 20;
endpackage : svd_pkg

// *** tb/svd_top_properties.sv ***
// Port checker of the supply threshold detector block.
// Assumes a bind onto the top module.
`timescale 1ns/1ns
module svd_top_properties (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        sleep_mode,
	input wire logic [3:0]  trip_level_select,
	input wire logic        detector_power,
	input wire logic        wake_request,
	input wire logic        vector_request
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	wire rq = avs_read | avs_write;
	wire rd = avs_read & ~avs_waitrequest;
	wire cw = avs_write & ~avs_waitrequest & (avs_address == svd_pkg::ADDR_CONTROL);
	property p_wait; rq && avs_waitrequest |=> !avs_waitrequest; endproperty
	a_wait: assert property (p_wait) else $error("no answer");
	property p_once; !avs_waitrequest |=> avs_waitrequest; endproperty
	a_once: assert property (p_once) else $error("answer too long");
	property p_unmap; rd && avs_address > 4'h4 |-> avs_readdata == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	property p_bit6; rd && avs_address == 4'h0 |-> avs_readdata[31:8] == 24'h0 && !avs_readdata[6]; endproperty
	a_bit6: assert property (p_bit6) else $error("bit six set");
	property p_copy; cw |=> ##1 {detector_power, trip_level_select} == $past(avs_writedata[4:0], 2); endproperty
	a_copy: assert property (p_copy) else $error("control copy");
	property p_hold; $changed({detector_power, trip_level_select}) |-> $past(cw) || $past(cw, 2); endproperty
	a_hold: assert property (p_hold) else $error("control moved");
	property p_wake; wake_request |-> $past(sleep_mode); endproperty
	a_wake: assert property (p_wake) else $error("wake awake");
	property p_vec; vector_request |-> wake_request; endproperty
	a_vec: assert property (p_vec) else $error("vector alone");
endmodule : svd_top_properties

// *** tb/svd_top_tb.sv ***
// Bench: registers, settling, events, sleep wake and reset.
// Assumes the package and checker are compiled first.
`timescale 1ns/1ns
module svd_top_tb;
	logic clk = 0, resetn = 0, avs_read = 0, avs_write = 0, settle_tick = 0, ref_user_enable = 0;
	logic divider_above = 0, external_trip_input = 0, sleep_mode = 0;
	logic [3:0] avs_address = 4'h0, trip_level_select;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic avs_waitrequest, detector_power, irq, wake_request, vector_request;
	logic [16:0] lf = 17'h12a99;
	logic [7:0] m_prio;
	int fails = 0, check_count = 0;
	svd_top #(.SETTLE_TICKS(2)) svd_top_inst (.*);
	function automatic logic [16:0] step(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction : step
	always #25 clk = ~clk;
	always @(posedge clk) begin
		lf <= step(lf);
		settle_tick <= lf[0];
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : conclude
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	task automatic waitfor(ref logic s);
		int n = 0;
		while (s !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		if (n >= 100) begin
			fails++;
			conclude();
		end
	endtask : waitfor
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		q = avs_readdata;
		avs_write <= 0;
		avs_read <= 0;
		@(posedge clk);
		if (n >= 20) begin
			fails++;
			conclude();
		end
	endtask : bus
	initial begin
		repeat (10) @(posedge clk);
		resetn <= 1;
		@(posedge clk);
		for (int a = 0; a < 6; a++) begin
			bus(0, (a == 5) ? 4'h9 : a[3:0], 32'h0);
			chk("reset value", q, (a == 0) ? 32'h5 : (a == 4) ? 32'h4 : 32'h0);
		end
		m_prio = lf[7:0];
		bus(1, svd_pkg::ADDR_PRIO2, {24'h0, m_prio});
		bus(0, svd_pkg::ADDR_PRIO2, 32'h0);
		chk("priority", q, {24'h0, m_prio});
		bus(1, svd_pkg::ADDR_CONTROL, 32'hff);
		bus(0, svd_pkg::ADDR_CONTROL, 32'h0);
		chk("control", q & 32'hdf, 32'h9f);
		for (int n = 0; n < 50 && !q[5]; n++) bus(0, svd_pkg::ADDR_CONTROL, 32'h0);
		chk("stable", q[5], 32'h1);
		ref_user_enable <= 1;
		repeat (4) @(posedge clk);
		bus(0, svd_pkg::ADDR_CONTROL, 32'h0);
		chk("restart", q[5], 32'h0);
		for (int n = 0; n < 50 && !q[5]; n++) bus(0, svd_pkg::ADDR_CONTROL, 32'h0);
		chk("stable again", q[5], 32'h1);
		$display("registers done");
		bus(1, svd_pkg::ADDR_FLAGS2, 32'h0);
		bus(1, svd_pkg::ADDR_ENABLES2, 32'h4);
		bus(1, svd_pkg::ADDR_CORE_INT, 32'h80);
		divider_above <= 1;
		repeat (8) @(posedge clk);
		chk("tap ignored", irq, 32'h0);
		external_trip_input <= 1;
		waitfor(irq);
		bus(0, svd_pkg::ADDR_FLAGS2, 32'h0);
		chk("flag", q, 32'h4);
		bus(1, svd_pkg::ADDR_FLAGS2, 32'h0);
		external_trip_input <= 0;
		repeat (8) @(posedge clk);
		chk("fall ignored", irq, 32'h0);
		$display("events done");
		bus(1, svd_pkg::ADDR_CONTROL, 32'h1f);
		bus(1, svd_pkg::ADDR_CORE_INT, 32'h0);
		sleep_mode <= 1;
		external_trip_input <= 1;
		repeat (30) @(posedge clk);
		external_trip_input <= 0;
		waitfor(wake_request);
		chk("vector", vector_request, 32'h0);
		chk("irq", irq, 32'h0);
		bus(1, svd_pkg::ADDR_CORE_INT, 32'h80);
		waitfor(vector_request);
		$display("sleep done");
		resetn <= 0;
		repeat (3) @(posedge clk);
		resetn <= 1;
		sleep_mode <= 0;
		@(posedge clk);
		chk("power", detector_power, 32'h0);
		bus(0, svd_pkg::ADDR_CONTROL, 32'h0);
		chk("control reset", q, 32'h5);
		$display("reset done");
		conclude();
	end
endmodule : svd_top_tb
bind svd_top svd_top_properties svd_top_properties_inst (.*);
